// ### src/fepc_pkg.sv
// constants and types for the flash erase/program host controller
package fepc_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] LAST_ADDR = 15'h7FFF;
    localparam logic [7:0] CMD_READ = 8'h00;
    localparam logic [7:0] CMD_RESET = 8'hFF;
    localparam logic [7:0] CMD_IDREAD = 8'h90;
    localparam logic [7:0] CMD_ERASE = 8'h20;
    localparam logic [7:0] CMD_ERVFY = 8'hA0;
    localparam logic [7:0] CMD_PROG = 8'h40;
    localparam logic [7:0] CMD_PGVFY = 8'hC0;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam int ERASE_TRIES = 1000;
    localparam int PROG_TRIES = 25;
    localparam int CLK_NS = 40;
    localparam int ERASE_PULSE_MS = 10;
    localparam int PROG_PULSE_US = 10;
    localparam int ERASE_CYC = (ERASE_PULSE_MS * 1000000 + CLK_NS - 1) / CLK_NS;
    localparam int PROG_CYC = (PROG_PULSE_US * 1000 + CLK_NS - 1) / CLK_NS;
    // strobe phases; 3 cycles each = 120 ns, read strobe 4 = 160 ns, well beyond glitch width
    localparam int SETUP_CYC = 3;
    localparam int STROBE_CYC = 3;
    localparam int HOLD_CYC = 3;
    localparam int READ_CYC = 4;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_SETUP = 2'b01,
        BUS_STROBE = 2'b10,
        BUS_HOLD = 2'b11
    } fepc_bus_e;
    typedef enum logic [3:0] {
        SQ_IDLE = 4'b0000,
        SQ_ZFILL = 4'b0001,
        SQ_ESETUP = 4'b0010,
        SQ_ERASE = 4'b0011,
        SQ_EWAIT = 4'b0100,
        SQ_EVFY = 4'b0101,
        SQ_PSETUP = 4'b0110,
        SQ_PROG = 4'b0111,
        SQ_PWAIT = 4'b1000,
        SQ_PVFY = 4'b1001,
        SQ_RESET = 4'b1010,
        SQ_DONE = 4'b1011,
        SQ_FAIL = 4'b1100,
        SQ_IDRD = 4'b1101
    } fepc_seq_e;
endpackage : fepc_pkg

// ### src/fepc_bus_if.sv
// request/answer carrier between sequencer and pin driver
`timescale 1ns/1ps
interface fepc_bus_if;
    import fepc_pkg::*;
    logic req;
    logic [1:0] op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic idle;
    logic done;
    logic [DATA_W-1:0] rdata;
    modport seq (output req, op, addr, wdata, input idle, done, rdata);
    modport drv (input req, op, addr, wdata, output idle, done, rdata);
endinterface : fepc_bus_if

// ### src/fepc_pin_drv.sv
// pin driver: one flash bus cycle per request
`timescale 1ns/1ps
module fepc_pin_drv
    import fepc_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    fepc_bus_if.drv bus,
    output logic ceN,
    output logic oeN,
    output logic weN,
    output logic [ADDR_W-1:0] flashAddr,
    output logic [DATA_W-1:0] dqOut,
    output logic dqOe,
    input wire logic [DATA_W-1:0] dqIn
);
    fepc_bus_e st_q;
    logic [2:0] cnt_q;
    logic isRd_q;
    assign bus.idle = (st_q == BUS_IDLE);
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            st_q <= BUS_IDLE;
            cnt_q <= 3'h0;
            isRd_q <= 1'b0;
            bus.done <= 1'b0;
        end else begin
            bus.done <= 1'b0;
            case (st_q)
                BUS_IDLE: begin
                    if (bus.req) begin
                        isRd_q <= (bus.op == OP_READ);
                        st_q <= BUS_SETUP;
                        cnt_q <= 3'(SETUP_CYC - 1);
                    end
                end
                BUS_SETUP: begin
                    if (cnt_q == 3'h0) begin
                        st_q <= BUS_STROBE;
                        cnt_q <= isRd_q ? 3'(READ_CYC - 1)
                                        : 3'(STROBE_CYC - 1);
                    end else begin
                        cnt_q <= cnt_q - 3'h1;
                    end
                end
                BUS_STROBE: begin
                    if (cnt_q == 3'h0) begin
                        st_q <= BUS_HOLD;
                        cnt_q <= 3'(HOLD_CYC - 1);
                    end else begin
                        cnt_q <= cnt_q - 3'h1;
                    end
                end
                BUS_HOLD: begin
                    if (cnt_q == 3'h0) begin
                        st_q <= BUS_IDLE;
                        bus.done <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q - 3'h1;
                    end
                end
                default: st_q <= BUS_IDLE;
            endcase
        end
    end
    // address and data held steady across the whole cycle: address
    // stable before we falls, data stable through its rise
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            flashAddr <= '0;
            dqOut <= '0;
        end else if (st_q == BUS_IDLE && bus.req) begin
            flashAddr <= bus.addr;
            dqOut <= bus.wdata;
        end
    end
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            bus.rdata <= '0;
        end else if (st_q == BUS_STROBE && isRd_q && cnt_q == 3'h0) begin
            bus.rdata <= dqIn;
        end
    end
    // strobes registered so no decode glitch reaches the pins
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ceN <= 1'b1;
            oeN <= 1'b1;
            weN <= 1'b1;
            dqOe <= 1'b0;
        end else begin
            ceN <= !(st_q != BUS_IDLE || bus.req);
            oeN <= !(isRd_q && st_q == BUS_STROBE);
            weN <= !(!isRd_q && st_q == BUS_STROBE);
            dqOe <= !isRd_q && st_q != BUS_IDLE;
        end
    end
endmodule : fepc_pin_drv

// ### src/fepc_host.sv
// host sequencer: zero fill, bulk erase, program and id read
`timescale 1ns/1ps
module fepc_host
    import fepc_pkg::*;
#(
    parameter int ERASE_CYCLES = ERASE_CYC,
    parameter int PROG_CYCLES = PROG_CYC,
    parameter logic [ADDR_W-1:0] LAST = LAST_ADDR
)
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic startErase,
    input wire logic startProg,
    input wire logic startId,
    input wire logic [ADDR_W-1:0] progAddr,
    input wire logic [DATA_W-1:0] progData,
    input wire logic programSupplyHigh,
    output logic busy,
    output logic opDone,
    output logic opFail,
    output logic [DATA_W-1:0] makerCode,
    output logic [DATA_W-1:0] deviceCode,
    output logic ceN,
    output logic oeN,
    output logic weN,
    output logic [ADDR_W-1:0] flashAddr,
    output logic [DATA_W-1:0] dqOut,
    output logic dqOe,
    input wire logic [DATA_W-1:0] dqIn,
    output logic programSupplyEnable
);
    fepc_bus_if bus ();
    fepc_pin_drv u_drv (
        .mclk(mclk),
        .rstn(rstn),
        .bus(bus),
        .ceN(ceN),
        .oeN(oeN),
        .weN(weN),
        .flashAddr(flashAddr),
        .dqOut(dqOut),
        .dqOe(dqOe),
        .dqIn(dqIn)
    );
    fepc_seq_e st_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] data_q;
    logic [9:0] tries_q;
    logic [19:0] wait_q;
    logic issued_q;
    logic eraseMode_q;
    logic idPhase_q;
    logic isErase_q;
    // a bus request is fired once per bus cycle, then we wait for done before the next
    function automatic logic [1:0] op_of(input fepc_seq_e s);
        case (s)
            SQ_EVFY, SQ_PVFY, SQ_IDRD: op_of = OP_READ;
            default: op_of = OP_WRITE;
        endcase
    endfunction : op_of
    logic needBus;
    logic [DATA_W-1:0] cmdByte;
    always_comb begin
        needBus = 1'b1;
        cmdByte = CMD_READ;
        case (st_q)
            SQ_ZFILL: cmdByte = CMD_PROG;
            SQ_ESETUP, SQ_ERASE: cmdByte = CMD_ERASE;
            SQ_EVFY: cmdByte = CMD_ERVFY;
            SQ_PSETUP: cmdByte = CMD_PROG;
            SQ_PROG: cmdByte = data_q;
            SQ_PVFY: cmdByte = CMD_PGVFY;
            SQ_RESET: cmdByte = CMD_RESET;
            SQ_IDRD: cmdByte = CMD_IDREAD;
            default: needBus = 1'b0;
        endcase
    end
    // the verify states issue a command write then a read: idPhase_q picks
    // no bus cycle starts until the program supply reports high
    assign bus.req = needBus && !issued_q && bus.idle
                     && programSupplyHigh;
    assign bus.op = (op_of(st_q) == OP_READ && idPhase_q) ? OP_READ : OP_WRITE;
    assign bus.addr = (st_q == SQ_EVFY || st_q == SQ_PROG
                       || st_q == SQ_IDRD) ? addr_q : '0;
    assign bus.wdata = cmdByte;
    assign busy = (st_q != SQ_IDLE);
    // the id command sequence writes the command register, so it needs
    // the supply as well
    assign programSupplyEnable = busy;
    logic verifyOk;
    assign verifyOk = isErase_q ? (bus.rdata == ERASED_BYTE)
                                : (bus.rdata == data_q);
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            st_q <= SQ_IDLE;
            addr_q <= '0;
            data_q <= '0;
            tries_q <= '0;
            wait_q <= '0;
            issued_q <= 1'b0;
            eraseMode_q <= 1'b0;
            idPhase_q <= 1'b0;
            isErase_q <= 1'b0;
            opDone <= 1'b0;
            opFail <= 1'b0;
            makerCode <= '0;
            deviceCode <= '0;
        end else begin
            opDone <= 1'b0;
            opFail <= 1'b0;
            if (bus.req) begin
                issued_q <= 1'b1;
            end
            if (bus.done) begin
                issued_q <= 1'b0;
            end
            case (st_q)
                SQ_IDLE: begin
                    tries_q <= '0;
                    idPhase_q <= 1'b0;
                    if (startErase) begin
                        eraseMode_q <= 1'b1;
                        addr_q <= '0;
                        data_q <= ZERO_BYTE;
                        st_q <= SQ_PSETUP;
                    end else if (startProg) begin
                        eraseMode_q <= 1'b0;
                        addr_q <= progAddr;
                        data_q <= progData;
                        st_q <= SQ_PSETUP;
                    end else if (startId) begin
                        addr_q <= '0;
                        st_q <= SQ_IDRD;
                    end
                end
                SQ_PSETUP: begin
                    isErase_q <= 1'b0;
                    if (bus.done) st_q <= SQ_PROG;
                end
                SQ_PROG: begin
                    wait_q <= 20'(PROG_CYCLES);
                    if (bus.done) st_q <= SQ_PWAIT;
                end
                SQ_PWAIT: begin
                    if (wait_q <= 20'h1) st_q <= SQ_PVFY;
                    else wait_q <= wait_q - 20'h1;
                end
                SQ_PVFY: begin
                    if (bus.done) begin
                        if (!idPhase_q) begin
                            idPhase_q <= 1'b1;
                        end else begin
                            idPhase_q <= 1'b0;
                            if (verifyOk && eraseMode_q && addr_q != LAST) begin
                                addr_q <= addr_q + 1'b1;
                                tries_q <= '0;
                                st_q <= SQ_PSETUP;
                            end else if (verifyOk && eraseMode_q) begin
                                addr_q <= '0;
                                tries_q <= '0;
                                st_q <= SQ_ESETUP;
                            end else if (verifyOk) begin
                                st_q <= SQ_RESET;
                            end else if (tries_q == 10'(PROG_TRIES - 1)) begin
                                opFail <= 1'b1;
                                st_q <= SQ_FAIL;
                            end else begin
                                tries_q <= tries_q + 10'h1;
                                st_q <= SQ_PSETUP;
                            end
                        end
                    end
                end
                SQ_ESETUP: begin
                    isErase_q <= 1'b1;
                    if (bus.done) st_q <= SQ_ERASE;
                end
                SQ_ERASE: begin
                    wait_q <= 20'(ERASE_CYCLES);
                    if (bus.done) st_q <= SQ_EWAIT;
                end
                SQ_EWAIT: begin
                    if (wait_q <= 20'h1) st_q <= SQ_EVFY;
                    else wait_q <= wait_q - 20'h1;
                end
                SQ_EVFY: begin
                    if (bus.done) begin
                        if (!idPhase_q) begin
                            idPhase_q <= 1'b1;
                        end else begin
                            idPhase_q <= 1'b0;
                            if (verifyOk && addr_q != LAST) begin
                                addr_q <= addr_q + 1'b1;
                            end else if (verifyOk) begin
                                st_q <= SQ_RESET;
                            end else if (tries_q == 10'(ERASE_TRIES - 1)) begin
                                opFail <= 1'b1;
                                st_q <= SQ_FAIL;
                            end else begin
                                tries_q <= tries_q + 10'h1;
                                st_q <= SQ_ESETUP;
                            end
                        end
                    end
                end
                SQ_IDRD: begin
                    if (bus.done && idPhase_q) begin
                        if (addr_q[0]) begin
                            deviceCode <= bus.rdata;
                            st_q <= SQ_RESET;
                        end else begin
                            makerCode <= bus.rdata;
                            addr_q <= addr_q + 1'b1;
                        end
                    end
                    if (bus.done) idPhase_q <= !idPhase_q;
                end
                SQ_RESET: begin
                    if (bus.done) begin
                        if (idPhase_q) begin
                            idPhase_q <= 1'b0;
                            st_q <= SQ_DONE;
                        end else begin
                            idPhase_q <= 1'b1;
                        end
                    end
                end
                SQ_DONE: begin
                    opDone <= 1'b1;
                    st_q <= SQ_IDLE;
                end
                SQ_FAIL: st_q <= SQ_RESET;
                default: st_q <= SQ_IDLE;
            endcase
        end
    end
endmodule : fepc_host

// ### tb/fepc_host_props.sv
// port-level checks of the flash erase/program host controller
`timescale 1ns/1ps
module fepc_host_props
    import fepc_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic busy,
    input wire logic opDone,
    input wire logic opFail,
    input wire logic ceN,
    input wire logic oeN,
    input wire logic weN,
    input wire logic [ADDR_W-1:0] flashAddr,
    input wire logic [DATA_W-1:0] dqOut,
    input wire logic dqOe,
    input wire logic programSupplyEnable
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    property p_writeQual;
        !weN |-> !ceN && oeN;
    endproperty
    a_writeQual: assert property (p_writeQual)
        else $error("write strobe without select or with gate low");
    property p_noContention;
        !oeN |-> !dqOe && weN;
    endproperty
    a_noContention: assert property (p_noContention)
        else $error("host drives data during a read");
    property p_strobeWidth;
        $fell(weN) |-> !weN [*3] ##1 weN;
    endproperty
    a_strobeWidth: assert property (p_strobeWidth)
        else $error("write strobe not three cycles wide");
    property p_setup;
        $fell(weN) |-> dqOe && !$past(ceN) && !$past(ceN, 2);
    endproperty
    a_setup: assert property (p_setup)
        else $error("select or data missing before strobe fall");
    property p_addrStable;
        !weN |-> $stable(flashAddr) && $stable(dqOut);
    endproperty
    a_addrStable: assert property (p_addrStable)
        else $error("address or data moved under the strobe");
    property p_hold;
        $rose(weN) |-> !ceN && dqOe && $stable(dqOut);
    endproperty
    a_hold: assert property (p_hold)
        else $error("data not held at strobe rise");
    property p_supply;
        !weN |-> programSupplyEnable;
    endproperty
    a_supply: assert property (p_supply)
        else $error("command written with program supply off");
    property p_quiet;
        !busy [*3] |-> ceN && weN && oeN && !dqOe;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("bus active while idle");
    property p_failThenDone;
        opFail |-> ##[1:300] opDone;
    endproperty
    a_failThenDone: assert property (p_failThenDone)
        else $error("no reset and completion after a failure");
    property p_pulse;
        opDone || opFail |=> !opDone && !opFail;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("completion flag longer than one cycle");

    c_write: cover property ($fell(weN));
    c_read: cover property ($fell(oeN));
    c_fail: cover property (opFail);
    c_done: cover property (opDone);
endmodule : fepc_host_props

bind fepc_host fepc_host_props i_props (.mclk(mclk), .rstn(rstn),
    .busy(busy), .opDone(opDone), .opFail(opFail), .ceN(ceN), .oeN(oeN),
    .weN(weN), .flashAddr(flashAddr), .dqOut(dqOut), .dqOe(dqOe),
    .programSupplyEnable(programSupplyEnable));

// ### tb/fepc_flash_model.sv
// behavioural flash device on the far side of the host controller
`timescale 1ns/1ps
module fepc_flash_model
    import fepc_pkg::*;
#(
    parameter int ERASE_LIM = 20,
    parameter int PROG_LIM = 5,
    parameter int DEPTH = 4,
    parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
    parameter logic [7:0] PART_ID = 8'h3C // arbitrary value
)
(
    input wire logic mclk,
    input wire logic ceN,
    input wire logic oeN,
    input wire logic weN,
    input wire logic [ADDR_W-1:0] flashAddr,
    input wire logic [DATA_W-1:0] dqOut,
    input wire logic programSupplyHigh,
    input wire logic supplyOk,
    input wire logic [7:0] eraseFails,
    output logic [DATA_W-1:0] dqIn
);
    logic [7:0] mem [DEPTH];
    logic [ADDR_W-1:0] aLatch, pAddr, eAddr;
    int tick, pulseT, mode, tooEarly, badErase, pulses, failsUsed;
    realtime fallT;
    bit retryPulse; // repeat pulses of one erase need no new zero fill

    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        mode = 0;
        {tick, pulseT, tooEarly, badErase, pulses, failsUsed} = '0;
    end
    always @(posedge mclk) tick <= tick + 1;
    // command register falls back to read on supply rise or lockout
    always @(posedge programSupplyHigh or negedge supplyOk)
        mode = 0;
    always @(negedge weN) begin
        fallT = $realtime;
        aLatch = flashAddr;
    end
    // pulse effects land at once; the stop timer bounds the early verify
    always @(posedge weN) begin
        if (!ceN && oeN && programSupplyHigh && supplyOk
            && $realtime - fallT >= 10.0) begin
            if (mode == 2 && dqOut == CMD_ERASE) begin
                if (!retryPulse)
                    foreach (mem[i]) if (mem[i] !== 8'h00) badErase++;
                retryPulse = 1'b1;
                foreach (mem[i]) mem[i] = 8'hFF;
                if (failsUsed < eraseFails) mem[1] = 8'h00;
                failsUsed += (failsUsed < eraseFails);
                pulseT = tick;
                mode = 3;
            end else if (mode == 5) begin
                pAddr = aLatch;
                mem[aLatch % DEPTH] = mem[aLatch % DEPTH] & dqOut;
                pulseT = tick;
                pulses++;
                retryPulse = 1'b0;
                mode = 6;
            end else if (dqOut == CMD_ERVFY) begin
                if (mode == 3 && tick - pulseT < ERASE_LIM) tooEarly++;
                eAddr = aLatch;
                mode = 4;
            end else if (dqOut == CMD_PGVFY) begin
                if (mode == 6 && tick - pulseT < PROG_LIM) tooEarly++;
                mode = 7;
            end else begin
                case (dqOut)
                    8'h20: mode = 2;
                    8'h40: mode = 5;
                    8'h80, 8'h90: mode = 1;
                    default: mode = 0;
                endcase
            end
        end
    end
    always @* begin
        if (!ceN && !oeN) begin
            case (mode)
                1: dqIn = flashAddr[0] ? PART_ID : MAKER_ID;
                4: dqIn = mem[eAddr % DEPTH];
                7: dqIn = mem[pAddr % DEPTH];
                default: dqIn = mem[flashAddr % DEPTH];
            endcase
        end else begin
            dqIn = tick[7:0] ^ 8'hA5;
        end
    end
endmodule : fepc_flash_model

// ### tb/tb_top.sv
// self-checking bench of the flash erase/program host controller
`timescale 1ns/1ps
module tb_top;
    import fepc_pkg::*;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic startErase = 1'b0, startProg = 1'b0, startId = 1'b0;
    logic [ADDR_W-1:0] progAddr = '0;
    logic [DATA_W-1:0] progData = '0;
    logic busy, opDone, opFail, ceN, oeN, weN, dqOe, supplyEn;
    logic [DATA_W-1:0] makerCode, deviceCode, dqOut, dqIn;
    logic [ADDR_W-1:0] flashAddr;
    logic supplyOk = 1'b1;
    logic [7:0] eraseFails = 8'h00;
    int err_count = 0, compares = 0, cycles = 0;
    bit sawFail;
    typedef struct {
        logic [14:0] addr;
        logic [7:0] data, expMem;
        bit expFail;
        int expPulses;
    } fepc_row_s;
    fepc_row_s rows [4] = '{'{15'h0000, 8'h3C, 8'h3C, 1'b0, 1},
        '{15'h0003, 8'h00, 8'h00, 1'b0, 1}, '{15'h0001, 8'h80, 8'h80, 1'b0, 1},
        '{15'h0001, 8'h7F, 8'h00, 1'b1, 25}};

    always #20 mclk = ~mclk;

    fepc_host #(.ERASE_CYCLES(20), .PROG_CYCLES(5), .LAST(15'h0003)) i_dut (
        .mclk(mclk), .rstn(rstn), .startErase(startErase),
        .startProg(startProg), .startId(startId), .progAddr(progAddr),
        .progData(progData), .programSupplyHigh(supplyEn), .busy(busy),
        .opDone(opDone), .opFail(opFail), .makerCode(makerCode),
        .deviceCode(deviceCode), .ceN(ceN), .oeN(oeN), .weN(weN),
        .flashAddr(flashAddr), .dqOut(dqOut), .dqOe(dqOe), .dqIn(dqIn),
        .programSupplyEnable(supplyEn));
    fepc_flash_model i_flash (.mclk(mclk), .ceN(ceN), .oeN(oeN), .weN(weN),
        .flashAddr(flashAddr), .dqOut(dqOut), .programSupplyHigh(supplyEn),
        .supplyOk(supplyOk), .eraseFails(eraseFails), .dqIn(dqIn));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic kick(input bit e, input bit p, input bit i);
        @(negedge mclk);
        startErase = e;
        startProg = p;
        startId = i;
        @(negedge mclk);
        {startErase, startProg, startId} = 3'b000;
    endtask : kick
    // waits for the completion pulse, noting any failure pulse on the way
    task automatic wait_done();
        int n;
        sawFail = 0;
        for (n = 0; n < 20000 && opDone !== 1'b1; n++) begin
            if (opFail === 1'b1) sawFail = 1;
            @(negedge mclk);
        end
        if (opDone !== 1'b1) begin
            err_count++;
            $display("ERROR t=%0t no completion pulse", $time);
            end_sim();
        end
    endtask : wait_done
    task automatic end_sim();
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_sim

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles >= 60000) begin
            err_count++;
            $display("ERROR t=%0t run too long", $time);
            end_sim();
        end
    end

    initial begin
        repeat (8) @(negedge mclk);
        rstn = 1'b1;
        foreach (rows[i]) begin
            int p0;
            p0 = i_flash.pulses;
            progAddr = rows[i].addr;
            progData = rows[i].data;
            kick(1'b0, 1'b1, 1'b0);
            wait_done();
            check(16'(sawFail), 16'(rows[i].expFail));
            check(16'(i_flash.pulses - p0), 16'(rows[i].expPulses));
            check(i_flash.mem[rows[i].addr], rows[i].expMem);
            $display("program row %0d finished", i);
        end
        eraseFails = 8'h02;
        kick(1'b1, 1'b0, 1'b0);
        wait_done();
        check(16'(sawFail), 16'h0000);
        check(16'(i_flash.failsUsed), 16'h0002);
        foreach (i_flash.mem[i]) check(i_flash.mem[i], ERASED_BYTE);
        check(16'(i_flash.badErase), 16'h0000);
        $display("erase with retries finished");
        kick(1'b0, 1'b0, 1'b1);
        progAddr = 15'h0003;
        progData = 8'h12;
        kick(1'b0, 1'b1, 1'b0);
        wait_done();
        check(makerCode, i_flash.MAKER_ID);
        check(deviceCode, i_flash.PART_ID);
        check(i_flash.mem[3], 8'hFF);
        $display("identifier read finished");
        supplyOk = 1'b0;
        progAddr = 15'h0002;
        progData = 8'h55;
        kick(1'b0, 1'b1, 1'b0);
        wait_done();
        supplyOk = 1'b1;
        check(16'(sawFail), 16'h0001);
        check(i_flash.mem[2], 8'hFF);
        check(16'(i_flash.tooEarly), 16'h0000);
        $display("lockout program finished");
        rstn = 1'b0;
        repeat (8) @(negedge mclk);
        check({busy, ceN, oeN, weN, dqOe, opDone}, 16'h001C);
        rstn = 1'b1;
        $display("reset finished");
        end_sim();
    end
endmodule : tb_top
